// *** pht_host.sv ***
// PIO host controller that times register and data cycles on the disk port
`timescale 1ns/1ps
module pht_host
    import pht_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Mode selection
    input wire logic [2:0] bus_mode,
    input wire logic [2:0] dev_mode,
    // Request port
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic req_data,
    input wire logic [1:0] req_cs,
    input wire logic [2:0] req_addr,
    input wire logic [DW-1:0] req_wdata,
    // Read data port
    output logic rd_valid,
    input wire logic rd_ready,
    output logic [DW-1:0] rd_data,
    // Status
    output logic busy,
    // Disk port pins
    output logic [1:0] cs_n,
    output logic [2:0] da,
    output logic dior_n,
    output logic diow_n,
    input wire logic [DW-1:0] dd_in,
    output logic [DW-1:0] dd_out,
    output logic dd_oe,
    input wire logic iordy
);

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SETUP,
        ST_ACTIVE,
        ST_RECOV
    } pht_state_t;

    typedef struct packed {
        pht_state_t st;
        pht_tim_t tim;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] cyc;
        logic wr;
        logic [1:0] last_cs;
        logic [2:0] last_da;
        logic [2:0] sync;
        logic rdy;
        logic req_ready;
        logic busy;
        logic [1:0] cs_n;
        logic [2:0] da;
        logic dior_n;
        logic diow_n;
        logic [DW-1:0] dd_out;
        logic dd_oe;
    } pht_host_st_t;

    pht_host_st_t st_ff;
    pht_host_st_t nxt_st;
    logic accept;
    logic push;
    logic buf_full_next;
    logic [2:0] sel_mode;
    logic act_done;
    logic rec_done;

    // ------------------------------------------------------------
    // Phase counting
    // ------------------------------------------------------------
    // A limit is met once the count stands one short of it, since the phase
    // ends on the following edge. Limits are never zero, so lim - 1 cannot
    // wrap, and a count held at saturation through a long stall still passes.
    function automatic logic cnt_reached(input logic [CNT_W-1:0] cnt,
                                         input logic [CNT_W-1:0] lim);
        return cnt >= lim - 8'h01;
    endfunction : cnt_reached

    pht_buf_if bif ();

    pht_buf u_buf (
        .clk_sys (clk_sys),
        .rst (rst),
        .bus (bif.buf_side)
    );

    // ------------------------------------------------------------
    // Read buffer hookup
    // ------------------------------------------------------------
    assign bif.in_valid = push;
    assign bif.in_data = dd_in;
    assign bif.out_ready = rd_ready;
    assign rd_valid = bif.out_valid;
    assign rd_data = bif.out_data;

    // Space is checked before taking any request, so a read never finds it full
    assign buf_full_next = !bif.in_ready && !(bif.out_valid && rd_ready);
    assign accept = req_valid && st_ff.req_ready;

    // ------------------------------------------------------------
    // Mode choice and phase completion
    // ------------------------------------------------------------
    always_comb begin
        sel_mode = bus_mode;
        if (req_data && req_cs == st_ff.last_cs && req_addr == st_ff.last_da) begin
            sel_mode = dev_mode;
        end
    end

    // Strobe held for the active minimum and past the ready sample point;
    // a low ready level stalls it with no timeout
    assign act_done = cnt_reached(st_ff.cnt, st_ff.tim.act)
        && (st_ff.cnt >= SAMPLE_CYC)
        && st_ff.rdy;
    // Both the recovery minimum and the whole-cycle minimum must be met
    assign rec_done = cnt_reached(st_ff.cnt, st_ff.tim.rec)
        && cnt_reached(st_ff.cyc, st_ff.tim.cyc);
    assign push = (st_ff.st == ST_ACTIVE) && act_done && !st_ff.wr;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        // Ready counts only once the last two stages agree
        nxt_st.sync = {st_ff.sync[1:0], iordy};
        if (st_ff.sync[1] == st_ff.sync[2]) begin
            nxt_st.rdy = st_ff.sync[2];
        end
        nxt_st.cnt = (st_ff.cnt == CNT_SAT) ? CNT_SAT : st_ff.cnt + 8'h01;
        nxt_st.cyc = (st_ff.cyc == CNT_SAT) ? CNT_SAT : st_ff.cyc + 8'h01;
        case (st_ff.st)
            ST_IDLE: begin
                if (accept) begin
                    nxt_st.st = ST_SETUP;
                    nxt_st.tim = mode_tim(sel_mode, req_data);
                    nxt_st.cnt = '0;
                    nxt_st.wr = req_write;
                    nxt_st.cs_n = ~req_cs;
                    nxt_st.da = req_addr;
                    nxt_st.last_cs = req_cs;
                    nxt_st.last_da = req_addr;
                    nxt_st.dd_out = req_wdata;
                    nxt_st.dd_oe = req_write;
                end
            end
            ST_SETUP: begin
                if (cnt_reached(st_ff.cnt, st_ff.tim.setup)) begin
                    nxt_st.st = ST_ACTIVE;
                    nxt_st.cnt = '0;
                    nxt_st.cyc = '0;
                    nxt_st.dior_n = st_ff.wr;
                    nxt_st.diow_n = !st_ff.wr;
                end
            end
            ST_ACTIVE: begin
                if (act_done) begin
                    nxt_st.st = ST_RECOV;
                    nxt_st.cnt = '0;
                    nxt_st.dior_n = 1'b1;
                    nxt_st.diow_n = 1'b1;
                end
            end
            ST_RECOV: begin
                // Address and write data stay put through recovery for hold time
                if (rec_done) begin
                    nxt_st.st = ST_IDLE;
                    nxt_st.dd_oe = 1'b0;
                end
            end
            default: begin
                nxt_st.st = ST_IDLE;
            end
        endcase
        nxt_st.busy = (nxt_st.st != ST_IDLE);
        nxt_st.req_ready = (nxt_st.st == ST_IDLE) && !accept && !buf_full_next;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_ff <= '0;
            st_ff.st <= ST_IDLE;
            st_ff.cs_n <= 2'h3;
            st_ff.dior_n <= 1'b1;
            st_ff.diow_n <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    assign req_ready = st_ff.req_ready;
    assign busy = st_ff.busy;
    assign cs_n = st_ff.cs_n;
    assign da = st_ff.da;
    assign dior_n = st_ff.dior_n;
    assign diow_n = st_ff.diow_n;
    assign dd_out = st_ff.dd_out;
    assign dd_oe = st_ff.dd_oe;

endmodule : pht_host

// *** pht_pkg.sv ***
// Shared constants, timing tables and helpers for the PIO host timing block
package pht_pkg;

    // ------------------------------------------------------------
    // Clock and widths
    // ------------------------------------------------------------
    localparam int CLK_NS = 40;
    localparam int DW = 16;
    localparam int CNT_W = 8;
    localparam logic [2:0] MODE_MAX = 3'h4;
    localparam logic [2:0] MODE_FLOW = 3'h3;

    // ------------------------------------------------------------
    // Timing figures in ns, indexed by PIO mode 0..4
    // ------------------------------------------------------------
    localparam int T0_REG_NS [5] = '{600, 383, 330, 180, 120};
    localparam int T0_DAT_NS [5] = '{600, 383, 240, 180, 120};
    localparam int T1_NS [5] = '{70, 50, 30, 30, 25};
    localparam int T2_REG_NS [5] = '{290, 290, 290, 80, 70};
    localparam int T2_DAT_NS [5] = '{165, 125, 100, 80, 70};
    localparam int T2I_NS [5] = '{0, 0, 0, 70, 25};
    localparam int TA_NS = 35;

    // ------------------------------------------------------------
    // Derived counts
    // ------------------------------------------------------------
    localparam int SYNC_STAGES = 3;
    localparam int TA_CYC = (TA_NS + CLK_NS - 1) / CLK_NS;
    // Synchroniser delay is added so the ready level seen is the one at tA
    localparam logic [CNT_W-1:0] SAMPLE_CYC = CNT_W'(TA_CYC + SYNC_STAGES);
    localparam logic [CNT_W-1:0] CNT_SAT = 8'hff;

    typedef struct packed {
        logic [CNT_W-1:0] setup;
        logic [CNT_W-1:0] act;
        logic [CNT_W-1:0] rec;
        logic [CNT_W-1:0] cyc;
    } pht_tim_t;

    // Least time: round up, never under one cycle
    function automatic logic [CNT_W-1:0] ns2cyc(input int ns);
        int c;
        c = (ns + CLK_NS - 1) / CLK_NS;
        if (c < 1) begin
            c = 1;
        end
        return CNT_W'(c);
    endfunction : ns2cyc

    function automatic pht_tim_t mode_tim(input logic [2:0] mode, input logic is_data);
        pht_tim_t t;
        int m;
        m = (mode > MODE_MAX) ? int'(MODE_MAX) : int'(mode);
        t.setup = ns2cyc(T1_NS[m]);
        t.act = ns2cyc(is_data ? T2_DAT_NS[m] : T2_REG_NS[m]);
        t.rec = ns2cyc(T2I_NS[m]);
        t.cyc = ns2cyc(is_data ? T0_DAT_NS[m] : T0_REG_NS[m]);
        return t;
    endfunction : mode_tim

endpackage : pht_pkg

// *** pht_buf_if.sv ***
// Push and pop handshake bundle between the host timer and its read buffer
`timescale 1ns/1ps
interface pht_buf_if;
    import pht_pkg::*;
    logic in_valid;
    logic in_ready;
    logic [DW-1:0] in_data;
    logic out_valid;
    logic out_ready;
    logic [DW-1:0] out_data;

    modport fill (output in_valid, output in_data, input in_ready,
                  input out_valid, input out_data, output out_ready);
    modport buf_side (input in_valid, input in_data, output in_ready,
                      output out_valid, output out_data, input out_ready);
endinterface : pht_buf_if

// *** pht_buf.sv ***
// Two-entry shift buffer for read words
`timescale 1ns/1ps
module pht_buf
    import pht_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Handshake bundle
    pht_buf_if.buf_side bus
);

    typedef struct packed {
        logic v0;
        logic v1;
        logic [DW-1:0] d0;
        logic [DW-1:0] d1;
    } pht_buf_st_t;

    pht_buf_st_t st_ff;
    pht_buf_st_t nxt_st;
    logic pop;
    logic push;

    assign pop = st_ff.v0 && bus.out_ready;
    assign push = bus.in_valid && !st_ff.v1;
    assign bus.in_ready = !st_ff.v1;
    assign bus.out_valid = st_ff.v0;
    assign bus.out_data = st_ff.d0;

    always_comb begin
        nxt_st = st_ff;
        if (pop) begin
            nxt_st.v0 = st_ff.v1;
            nxt_st.d0 = st_ff.d1;
            nxt_st.v1 = 1'b0;
        end
        if (push) begin
            if (!nxt_st.v0) begin
                nxt_st.v0 = 1'b1;
                nxt_st.d0 = bus.in_data;
            end else begin
                nxt_st.v1 = 1'b1;
                nxt_st.d1 = bus.in_data;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

endmodule : pht_buf

// *** pht_host_sva.sv ***
// Assertion checker for the PIO host pins and request handshake
`timescale 1ns/1ps
module pht_host_sva
    import pht_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Request side
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic rd_valid,
    input wire logic busy,
    // Disk port
    input wire logic [1:0] cs_n,
    input wire logic [2:0] da,
    input wire logic dior_n,
    input wire logic diow_n,
    input wire logic dd_oe,
    input wire logic iordy
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    wire logic act = !(dior_n && diow_n);
    property p_acc; req_valid && req_ready |=> busy && !req_ready; endproperty
    a_acc: assert property (p_acc) else $error("accept without busy");
    property p_rd_act; $fell(dior_n) |-> !dior_n [*5]; endproperty
    a_rd_act: assert property (p_rd_act) else $error("read strobe short");
    property p_wr_act; $fell(diow_n) |-> !diow_n [*5]; endproperty
    a_wr_act: assert property (p_wr_act) else $error("write strobe short");
    property p_stall; (act && !iordy) [*4] |=> act; endproperty
    a_stall: assert property (p_stall) else $error("cycle ended while not ready");
    property p_rec; $rose(dior_n) || $rose(diow_n) |-> busy && !act; endproperty
    a_rec: assert property (p_rec) else $error("no recovery time");
    property p_addr; act |-> $stable(cs_n) && $stable(da); endproperty
    a_addr: assert property (p_addr) else $error("select moved in strobe");
    property p_setup; $fell(dior_n) || $fell(diow_n) |-> $past(busy); endproperty
    a_setup: assert property (p_setup) else $error("strobe without setup");
    property p_idle; !busy |-> !act && !dd_oe; endproperty
    a_idle: assert property (p_idle) else $error("pins active while idle");
    property p_rdv; $rose(dior_n) && !rd_valid |-> ##[0:2] rd_valid; endproperty
    a_rdv: assert property (p_rdv) else $error("read word not delivered");
endmodule : pht_host_sva

bind pht_host pht_host_sva u_sva (.clk_sys(clk_sys), .rst(rst), .req_valid(req_valid),
    .req_ready(req_ready), .rd_valid(rd_valid), .busy(busy), .cs_n(cs_n), .da(da),
    .dior_n(dior_n), .diow_n(diow_n), .dd_oe(dd_oe), .iordy(iordy));

// *** pht_dev.sv ***
// Behavioural disk device that answers PIO cycles and can stretch them
`timescale 1ns/1ps
module pht_dev
    import pht_pkg::*;
(
    // Clock
    input wire logic clk_sys,
    // Disk port
    input wire logic [2:0] da,
    input wire logic dior_n,
    input wire logic diow_n,
    input wire logic [DW-1:0] dd_out,
    output logic [DW-1:0] dd_in,
    output logic iordy,
    // Test control
    input wire logic [CNT_W-1:0] stall,
    output logic [DW-1:0] wr_word
);
    localparam logic [2:0] PWR_MODE = 3'h0;
    localparam int ID68_NS = 120;
    logic [CNT_W-1:0] left = 8'h00;
    logic [DW-1:0] last = 16'h0000;
    logic strb = 1'b0;
    wire logic act = !(dior_n && diow_n);
    initial wr_word = 16'h0000;
    // Any legal active and recovery split is accepted: no timing checks here
    assign iordy = act ? (strb ? left == 8'h00 : stall == 8'h00) : 1'b1;
    // Released bus toggles so a late sample never sees a stale word
    assign dd_in = (!dior_n && iordy) ? {8'hc3, 5'h00, da} : ~last;
    always @(posedge clk_sys) begin
        strb <= act;
        last <= dd_in;
        if (act && !strb) begin
            left <= (stall == 8'h00) ? 8'h00 : stall - 8'h01;
        end else if (left != 8'h00) begin
            left <= left - 8'h01;
        end
        if (!diow_n) begin
            wr_word <= dd_out;
        end
    end
endmodule : pht_dev

// *** tb_top.sv ***
// Self-checking testbench for the PIO host timer
`timescale 1ns/1ps
module tb_top;
    import pht_pkg::*;
    logic clk_sys = 1'b0, rst = 1'b1, req_valid = 1'b0, req_write = 1'b0, req_data = 1'b0;
    logic rd_ready = 1'b0, req_ready, rd_valid, busy, dior_n, diow_n, dd_oe, iordy;
    logic [2:0] bus_mode = 3'h0, dev_mode = 3'h0, req_addr = 3'h0, da;
    logic [1:0] req_cs = 2'h0, cs_n;
    logic [DW-1:0] req_wdata = 16'h0000, rd_data, dd_in, dd_out, wr_word;
    logic [CNT_W-1:0] stall = 8'h00;
    int n_fail = 0;
    int cmp_count = 0;
    always #20 clk_sys = ~clk_sys;
    pht_host dut (.clk_sys(clk_sys), .rst(rst), .bus_mode(bus_mode), .dev_mode(dev_mode),
        .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
        .req_data(req_data), .req_cs(req_cs), .req_addr(req_addr), .req_wdata(req_wdata),
        .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data), .busy(busy),
        .cs_n(cs_n), .da(da), .dior_n(dior_n), .diow_n(diow_n), .dd_in(dd_in),
        .dd_out(dd_out), .dd_oe(dd_oe), .iordy(iordy));
    pht_dev u_dev (.clk_sys(clk_sys), .da(da), .dior_n(dior_n), .diow_n(diow_n),
        .dd_out(dd_out), .dd_in(dd_in), .iordy(iordy), .stall(stall), .wr_word(wr_word));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic int cyc(input int ns);
        int c;
        c = (ns + CLK_NS - 1) / CLK_NS;
        return (c < 1) ? 1 : c;
    endfunction : cyc
    task automatic wrap_up;
        if (n_fail == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : wrap_up
    task automatic chk_ge(input int got, input int lim);
        cmp_count++;
        if (got < lim) begin
            n_fail++;
            $display("ERROR %0t count %0d under %0d", $time, got, lim);
        end
    endtask : chk_ge
    task automatic chk_eq(input logic [DW-1:0] got, input logic [DW-1:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t got %h want %h", $time, got, exp);
        end
    endtask : chk_eq
    // Active cycles and active-plus-recovery cycles of one transfer
    task automatic xfer(input logic w, d, input logic [2:0] ad, input logic [DW-1:0] wd,
                        output int a, output int t);
        int n;
        a = 0;
        t = 0;
        n = 0;
        {req_write, req_data, req_cs, req_addr, req_wdata} = {w, d, 2'h1, ad, wd};
        req_valid = 1'b1;
        while (req_ready !== 1'b1 && n < 500) begin @(negedge clk_sys); n++; end
        @(negedge clk_sys);
        req_valid = 1'b0;
        while (!(busy === 1'b0 && a > 0) && n < 2000) begin
            if (dior_n === 1'b0 || diow_n === 1'b0) a++;
            if (a > 0) t++;
            @(negedge clk_sys);
            n++;
        end
        chk_ge(1999, n);
    endtask : xfer
    task automatic pop(input logic [2:0] ad);
        int n = 0;
        while (rd_valid !== 1'b1 && n < 50) begin @(negedge clk_sys); n++; end
        chk_eq({15'h0000, rd_valid}, 16'h0001);
        chk_eq(rd_data, {8'hc3, 5'h00, ad});
        rd_ready = 1'b1;
        @(negedge clk_sys);
        rd_ready = 1'b0;
        @(negedge clk_sys);
    endtask : pop
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_modes;
        int a, t;
        for (int m = 0; m < 5; m++) begin
            {bus_mode, dev_mode} = {3'(m), 3'(m)};
            xfer(1'b1, 1'b0, 3'(m), 16'h00a0 + 16'(m), a, t);
            chk_ge(a, cyc(T2_REG_NS[m]));
            chk_ge(t, cyc(T0_REG_NS[m]));
            chk_ge(t - a, cyc(T2I_NS[m]));
            chk_eq({8'h00, wr_word[7:0]}, 16'h00a0 + 16'(m));
            xfer(1'b0, 1'b1, 3'(m), 16'h0000, a, t);
            chk_ge(a, cyc(T2_DAT_NS[m]));
            chk_ge(t, cyc(T0_DAT_NS[m]));
            pop(3'(m));
        end
    endtask : t_modes
    task automatic t_pick;
        int a, t;
        chk_ge(u_dev.ID68_NS, T0_REG_NS[MODE_MAX]);
        chk_ge(2, int'(u_dev.PWR_MODE));
        {bus_mode, dev_mode} = {3'h0, 3'h4};
        xfer(1'b0, 1'b1, 3'h3, 16'h0000, a, t);
        chk_ge(t, cyc(T0_DAT_NS[0]));
        pop(3'h3);
        xfer(1'b0, 1'b1, 3'h3, 16'h0000, a, t);
        chk_ge(cyc(T0_DAT_NS[0]) - 1, t);
        pop(3'h3);
        xfer(1'b0, 1'b0, 3'h3, 16'h0000, a, t);
        chk_ge(a, cyc(T2_REG_NS[0]));
        pop(3'h3);
    endtask : t_pick
    task automatic t_stall;
        int a, t;
        {bus_mode, dev_mode, stall} = {3'h7, 3'h7, 8'h1e};
        xfer(1'b1, 1'b1, 3'h3, 16'hbeef, a, t);
        chk_ge(a, 30);
        chk_eq(wr_word, 16'hbeef);
        xfer(1'b0, 1'b1, 3'h3, 16'h0000, a, t);
        chk_ge(a, 30);
        pop(3'h3);
        stall = 8'h00;
    endtask : t_stall
    task automatic t_buf;
        int a, t, bad;
        bad = 0;
        xfer(1'b0, 1'b1, 3'h5, 16'h0000, a, t);
        xfer(1'b0, 1'b1, 3'h6, 16'h0000, a, t);
        {req_addr, req_valid} = {3'h7, 1'b1};
        repeat (20) begin
            @(negedge clk_sys);
            if (dior_n === 1'b0 || req_ready === 1'b1) bad++;
        end
        req_valid = 1'b0;
        chk_ge(0, bad);
        pop(3'h5);
        xfer(1'b0, 1'b1, 3'h7, 16'h0000, a, t);
        pop(3'h6);
        pop(3'h7);
    endtask : t_buf
    // Run is a few hundred cycles; this 20000-cycle limit leaves a wide margin
    initial begin
        #800000;
        n_fail++;
        wrap_up();
    end
    initial begin
        repeat (8) @(posedge clk_sys);
        @(negedge clk_sys);
        rst = 1'b0;
        repeat (4) @(negedge clk_sys);
        t_modes();
        t_pick();
        t_stall();
        t_buf();
        wrap_up();
    end
endmodule : tb_top
